// >>> inc/tsisf_pkg.sv
package tsisf_pkg;

	// ------------------------------------------------------------
	// Clock and bus timing
	// ------------------------------------------------------------
	localparam int CLK_HZ       = 40000000;	// Reference clock rate
	localparam int FAST_SCL_HZ  = 400000;	// Fast mode bus clock
	localparam int HS_SCL_HZ    = 2000000;	// High-speed bus clock
	// Shortest bus clock half period in reference cycles
	localparam int HS_HALF_CYC  = CLK_HZ / (2 * HS_SCL_HZ);
	localparam int FAST_HALF_CYC = CLK_HZ / (2 * FAST_SCL_HZ);

	// ------------------------------------------------------------
	// Byte framing and result layout
	// ------------------------------------------------------------
	localparam logic [3:0]  BYTE_BITS   = 4'h8;	// Bits per byte
	localparam logic [3:0]  CNT_ZERO    = 4'h0;	// Bit counter start
	localparam logic [3:0]  LSB_PAD     = 4'h0;	// Trailing zero bits
	localparam logic [11:0] TEMP_RST    = 12'h000;	// Zero degrees
	localparam logic [11:0] TEMP_MAX    = 12'h7ff;	// Saturated positive
	localparam logic [11:0] TEMP_MIN    = 12'h800;	// Saturated negative
	localparam logic signed [15:0] CONV_MAX_S = 16'sh07ff;	// Top in range
	localparam logic signed [15:0] CONV_MIN_S = 16'shf800;	// Bottom in range
	localparam logic [7:0]  PTR_TEMP    = 8'h00;	// Result pointer value
	localparam logic [7:0]  PTR_RST     = 8'h00;	// Pointer after reset
	localparam logic [7:0]  BYTE_ZERO   = 8'h00;	// Filler byte

	// ------------------------------------------------------------
	// Resolution select codes and result masks
	// ------------------------------------------------------------
	localparam logic [1:0]  RES_9  = 2'h0;	// Nine bits
	localparam logic [1:0]  RES_10 = 2'h1;	// Ten bits
	localparam logic [1:0]  RES_11 = 2'h2;	// Eleven bits
	localparam logic [1:0]  RES_12 = 2'h3;	// Twelve bits
	localparam logic [11:0] MASK_9  = 12'hff8;
	localparam logic [11:0] MASK_10 = 12'hffc;
	localparam logic [11:0] MASK_11 = 12'hffe;
	localparam logic [11:0] MASK_12 = 12'hfff;

	// ------------------------------------------------------------
	// Slave address forming
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR8_BASE = 4'h9;	// Upper bits, eight-address part
	localparam logic [6:0] ADDR_RST   = 7'h48;	// Address before first sample

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic floating;	// Pin left open
		logic level;	// Pin level when driven
	} tsisf_pin_t;

	typedef struct packed {
		tsisf_pin_t addr_strap_bit2;
		tsisf_pin_t addr_strap_bit1;
		tsisf_pin_t addr_strap_bit0;
	} tsisf_strap_t;

	typedef struct packed {
		logic              valid;	// Conversion finished this cycle
		logic signed [15:0] temp;	// Sixteenths of a degree
	} tsisf_conv_t;

	typedef enum logic [7:0] {
		ST_IDLE     = 8'h01,
		ST_ADDR     = 8'h02,
		ST_ADDR_ACK = 8'h04,
		ST_WR_BYTE  = 8'h08,
		ST_WR_ACK   = 8'h10,
		ST_RD_BYTE  = 8'h20,
		ST_RD_ACK   = 8'h40,
		ST_IGNORE   = 8'h80
	} tsisf_state_t;

endpackage

// >>> rtl/tsisf_strap.sv
`timescale 1ns/1ps
module tsisf_strap
(
	input  wire logic                    clk,	// Reference clock
	input  wire logic                    rst,	// Synchronous reset
	input  wire logic                    sample,	// Take strap levels now
	input  wire logic                    variant_27,	// Three-level decode
	input  wire tsisf_pkg::tsisf_strap_t strap,	// Strap pin states
	output logic [6:0]                   addr	// Latched slave address
);
	import tsisf_pkg::*;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	// Pin state as a trit: 0 low, 1 high, 2 open
	function automatic logic [1:0] trit(input tsisf_pin_t p);
		trit = p.floating ? 2'h2 : {1'b0, p.level};
	endfunction

	// Three-level table over all 27 pin combinations
	function automatic logic [6:0] addr27(input tsisf_strap_t s);
		logic [5:0] key;
		key = {trit(s.addr_strap_bit2), trit(s.addr_strap_bit1), trit(s.addr_strap_bit0)};
		case (key)
			6'h00: addr27 = 7'h48;
			6'h01: addr27 = 7'h49;
			6'h04: addr27 = 7'h4a;
			6'h05: addr27 = 7'h4b;
			6'h10: addr27 = 7'h4c;
			6'h11: addr27 = 7'h4d;
			6'h14: addr27 = 7'h4e;
			6'h15: addr27 = 7'h4f;
			6'h20: addr27 = 7'h70;
			6'h22: addr27 = 7'h71;
			6'h21: addr27 = 7'h72;
			6'h24: addr27 = 7'h73;
			6'h26: addr27 = 7'h74;
			6'h25: addr27 = 7'h75;
			6'h28: addr27 = 7'h76;
			6'h29: addr27 = 7'h77;
			6'h08: addr27 = 7'h28;
			6'h09: addr27 = 7'h29;
			6'h18: addr27 = 7'h2a;
			6'h19: addr27 = 7'h2b;
			6'h02: addr27 = 7'h2c;
			6'h06: addr27 = 7'h2d;
			6'h12: addr27 = 7'h2e;
			6'h16: addr27 = 7'h2f;
			6'h0a: addr27 = 7'h35;
			6'h1a: addr27 = 7'h36;
			6'h2a: addr27 = 7'h37;
			default: addr27 = ADDR_RST;
		endcase
	endfunction

	// Latch the decoded address on each sample
	always_ff @(posedge clk)
	begin
		if (rst)
			addr <= ADDR_RST;
		else if (sample && variant_27)
			addr <= addr27(strap);
		else if (sample)
			addr <= {ADDR8_BASE, strap.addr_strap_bit2.level,
				strap.addr_strap_bit1.level, strap.addr_strap_bit0.level};
	end

	AST_ADDR8_FORM: assert property (@(posedge clk) disable iff (rst)
		sample && !variant_27 |=> addr[6:3] == ADDR8_BASE
			&& addr[0] == $past(strap.addr_strap_bit0.level))
		else $error("eight-address form wrong");

endmodule

// >>> rtl/tsisf_result.sv
`timescale 1ns/1ps
module tsisf_result
(
	input  wire logic                   clk,	// Reference clock
	input  wire logic                   rst,	// Synchronous reset
	input  wire tsisf_pkg::tsisf_conv_t conv,	// Finished conversion
	input  wire logic [1:0]             res_sel,	// Resolution select
	output logic [11:0]                 result	// Temperature result
);
	import tsisf_pkg::*;

	logic [11:0] next_result;
	logic [11:0] sat;

	// Saturate, then clear the unused low bits
	always_comb
	begin
		if (conv.temp > CONV_MAX_S)
			sat = TEMP_MAX;
		else if (conv.temp < CONV_MIN_S)
			sat = TEMP_MIN;
		else
			sat = conv.temp[11:0];
		case (res_sel)
			RES_9:   next_result = sat & MASK_9;
			RES_10:  next_result = sat & MASK_10;
			RES_11:  next_result = sat & MASK_11;
			RES_12:  next_result = sat & MASK_12;
			default: next_result = sat;
		endcase
	end

	// Only a finished conversion updates the result
	always_ff @(posedge clk)
	begin
		if (rst)
			result <= TEMP_RST;
		else if (conv.valid)
			result <= next_result;
	end

	AST_RESULT_HOLD: assert property (@(posedge clk) disable iff (rst)
		!$past(conv.valid) && !$past(rst) |-> $stable(result))
		else $error("result moved without a conversion");
	AST_RES9_LOW: assert property (@(posedge clk) disable iff (rst)
		conv.valid && res_sel == RES_9 |=> result[2:0] == 3'h0)
		else $error("low bits not cleared at nine bits");
	AST_SATURATE: assert property (@(posedge clk) disable iff (rst)
		conv.valid && res_sel == RES_12 && conv.temp > CONV_MAX_S
			|=> result == TEMP_MAX)
		else $error("high temperature not saturated");
	AST_RESET_ZERO: assert property (@(posedge clk)
		$past(rst) |-> result == TEMP_RST)
		else $error("result not zero after reset");

endmodule

// >>> rtl/tsisf_slave.sv
`timescale 1ns/1ps

//Operation
// - Result register holds latest conversion; bus writes never change it.
// - Result read gives two bytes, value in top 12 bits, rest zero.
// - Negative temperatures appear as twos complement codes.
// - Result reads zero after reset until first conversion completes.
// - Lower resolutions clear the unused low result bits.
// - One code step equals one sixteenth of a degree.
// - Temperatures of 128 degrees or more saturate at 7FF with the unused low bits cleared.
// - Device is slave only; data line driven open-drain, clock never driven.
// - Bus handled at fast and high-speed clock rates.
// - Every byte moves most significant bit first.
// - Data falling while clock high is START; address shifting begins.
// - First byte: seven address bits then read/write bit.
// - Matching address acknowledged by holding data low on ninth pulse.
// - Each byte is eight pulses plus one receiver acknowledge.
// - Data changes only with clock low; otherwise it is START or STOP.
// - Data rising while clock high is STOP, ending the transfer.
// - Three-level strap variant decodes 27 addresses.
// - Binary strap variant forms address 1001 plus pin levels.
// - Straps sampled after reset, on START, and on acquire request.
// - First written byte after address loads the register pointer.
// - Multi-byte registers go most significant byte first.
// - Two resolution bits pick nine to twelve bits.
module tsisf_slave
(
	input  wire logic                    REF_CLK,	// Reference clock
	input  wire logic                    SYS_RST,	// Synchronous reset, high
	input  wire logic                    SCL_IN,	// Bus clock level
	input  wire logic                    SDA_IN,	// Bus data level
	output logic                         SDA_OUT,	// Data output value, always low
	output logic                         SDA_OE,	// High while pulling data low
	input  wire tsisf_pkg::tsisf_strap_t STRAP,	// Address strap pins
	input  wire logic                    VARIANT_27,	// Three-level strap decode
	input  wire logic                    ADDR_ACQUIRE,	// Resample straps
	input  wire tsisf_pkg::tsisf_conv_t  CONV,	// Conversion result in
	input  wire logic                    RES_SEL_LOW,	// Resolution select, low bit
	input  wire logic                    RES_SEL_HIGH,	// Resolution select, high bit
	output logic [11:0]                  TEMP_RESULT,	// Temperature result
	output logic [6:0]                   SLAVE_ADDR,	// Latched slave address
	output logic [7:0]                   REG_POINTER,	// Register pointer
	output logic                         BUS_ACTIVE	// Addressed transfer running
);
	import tsisf_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	tsisf_state_t state;
	logic         scl_q;
	logic         sda_q;
	logic         start_det;
	logic         stop_det;
	logic         scl_rise;
	logic         scl_fall;
	logic [3:0]   bit_cnt;
	logic [7:0]   rx_shift;
	logic [7:0]   tx_shift;
	logic         drive_low;
	logic         first_wr;
	logic         byte_sel;
	logic         master_nack;
	logic         post_rst;
	logic         strap_sample;
	logic         addr_match;
	logic [7:0]   msb_byte;
	logic [7:0]   lsb_byte;
	logic [7:0]   next_byte;
	logic [11:0]  result;
	logic [6:0]   addr;

	// True once the eighth bit of a byte has been clocked in
	function automatic logic byte_full(input logic [3:0] cnt);
		byte_full = (cnt == BYTE_BITS);
	endfunction

	// ------------------------------------------------------------
	// Bus sampling and condition detect
	// ------------------------------------------------------------
	// Previous levels for edge detection
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= SCL_IN;
			sda_q <= SDA_IN;
		end
	end

	// Edges and bus conditions
	assign scl_rise  = SCL_IN && !scl_q;
	assign scl_fall  = !SCL_IN && scl_q;
	assign start_det = SCL_IN && scl_q && sda_q && !SDA_IN;
	assign stop_det  = SCL_IN && scl_q && !sda_q && SDA_IN;

	// ------------------------------------------------------------
	// Strap sampling and address
	// ------------------------------------------------------------
	// Pulse after reset release, on START and on acquire
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
			post_rst <= 1'b1;
		else
			post_rst <= 1'b0;
	end

	// Straps assumed settled before the bus starts
	assign strap_sample = post_rst || start_det || ADDR_ACQUIRE;

	tsisf_strap u_strap (
		.clk        (REF_CLK),
		.rst        (SYS_RST),
		.sample     (strap_sample),
		.variant_27 (VARIANT_27),
		.strap      (STRAP),
		.addr       (addr)
	);

	// Seven address bits, direction bit last
	assign addr_match = (rx_shift[7:1] == addr);

	// ------------------------------------------------------------
	// Temperature result
	// ------------------------------------------------------------
	tsisf_result u_result (
		.clk     (REF_CLK),
		.rst     (SYS_RST),
		.conv    (CONV),
		.res_sel ({RES_SEL_HIGH, RES_SEL_LOW}),
		.result  (result)
	);

	// Result bytes, value in upper twelve bits
	assign msb_byte  = result[11:4];
	assign lsb_byte  = {result[3:0], LSB_PAD};
	// Byte to send next, high byte first
	always_comb
	begin
		if (REG_POINTER != PTR_TEMP)
			next_byte = BYTE_ZERO;
		else if (byte_sel)
			next_byte = lsb_byte;
		else
			next_byte = msb_byte;
	end

	// ------------------------------------------------------------
	// Transfer state machine
	// ------------------------------------------------------------
	// Sequencing of address, acknowledge and data phases
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
			state <= ST_IDLE;
		else if (start_det)
			state <= ST_ADDR;
		else if (stop_det)
			state <= ST_IDLE;
		else
		begin
			case (state)
				ST_IDLE:
					state <= ST_IDLE;
				ST_ADDR:
					if (scl_fall && byte_full(bit_cnt))
						state <= addr_match ? ST_ADDR_ACK : ST_IGNORE;
				ST_ADDR_ACK:
					if (scl_fall)
						state <= rx_shift[0] ? ST_RD_BYTE : ST_WR_BYTE;
				ST_WR_BYTE:
					if (scl_fall && byte_full(bit_cnt))
						state <= ST_WR_ACK;
				ST_WR_ACK:
					if (scl_fall)
						state <= ST_WR_BYTE;
				ST_RD_BYTE:
					if (scl_fall && byte_full(bit_cnt))
						state <= ST_RD_ACK;
				ST_RD_ACK:
					if (scl_fall)
						state <= master_nack ? ST_IGNORE : ST_RD_BYTE;
				ST_IGNORE:
					state <= ST_IGNORE;
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Bit counting and receive shifting
	// ------------------------------------------------------------
	// Count rising clock edges within a byte
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST || start_det)
			bit_cnt <= CNT_ZERO;
		else if (scl_fall && (byte_full(bit_cnt) || state == ST_ADDR_ACK
				|| state == ST_WR_ACK || state == ST_RD_ACK))
			bit_cnt <= CNT_ZERO;
		else if (scl_rise && !byte_full(bit_cnt))
			bit_cnt <= bit_cnt + 4'h1;
	end

	// Shift in, first bit lands at the top
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
			rx_shift <= BYTE_ZERO;
		else if (scl_rise && (state == ST_ADDR || state == ST_WR_BYTE))
			rx_shift <= {rx_shift[6:0], SDA_IN};
	end

	// Master acknowledge after each sent byte
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
			master_nack <= 1'b0;
		else if (scl_rise && state == ST_RD_ACK)
			master_nack <= SDA_IN;
	end

	// ------------------------------------------------------------
	// Pointer register
	// ------------------------------------------------------------
	// First written byte is the pointer; later data bytes dropped
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
			first_wr <= 1'b0;
		else if (state == ST_ADDR_ACK && scl_fall)
			first_wr <= 1'b1;
		else if (state == ST_WR_BYTE && scl_fall && byte_full(bit_cnt))
			first_wr <= 1'b0;
	end

	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
			REG_POINTER <= PTR_RST;
		else if (state == ST_WR_BYTE && scl_fall && byte_full(bit_cnt) && first_wr)
			REG_POINTER <= rx_shift;
	end

	// ------------------------------------------------------------
	// Transmit path
	// ------------------------------------------------------------
	// High byte first on every new read
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST || start_det)
			byte_sel <= 1'b0;
		else if (state == ST_RD_BYTE && scl_fall && byte_full(bit_cnt))
			byte_sel <= !byte_sel;
	end

	// Load a byte at each read phase start, shift on falling edges
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
			tx_shift <= BYTE_ZERO;
		else if (scl_fall && ((state == ST_ADDR_ACK && rx_shift[0])
				|| (state == ST_RD_ACK && !master_nack)))
			tx_shift <= next_byte;
		else if (scl_fall && state == ST_RD_BYTE && !byte_full(bit_cnt))
			tx_shift <= {tx_shift[6:0], 1'b0};
	end

	// Open-drain pull, changed on falling clock, released on START or STOP
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST || start_det || stop_det)
			drive_low <= 1'b0;
		else if (scl_fall)
		begin
			case (state)
				ST_ADDR:
					drive_low <= byte_full(bit_cnt) && addr_match;
				ST_ADDR_ACK:
					drive_low <= rx_shift[0] && !next_byte[7];
				ST_WR_BYTE:
					drive_low <= byte_full(bit_cnt);
				ST_RD_BYTE:
					drive_low <= !byte_full(bit_cnt) && !tx_shift[6];
				ST_RD_ACK:
					drive_low <= !master_nack && !next_byte[7];
				default:
					drive_low <= 1'b0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Data pin only ever pulled low, clock never driven
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			SDA_OUT <= 1'b0;
			SDA_OE  <= 1'b0;
		end
		else
		begin
			SDA_OUT <= 1'b0;
			SDA_OE  <= drive_low && !start_det && !stop_det;
		end
	end

	// Status copies
	always_ff @(posedge REF_CLK)
	begin
		if (SYS_RST)
		begin
			TEMP_RESULT <= TEMP_RST;
			SLAVE_ADDR  <= ADDR_RST;
			BUS_ACTIVE  <= 1'b0;
		end
		else
		begin
			TEMP_RESULT <= result;
			SLAVE_ADDR  <= addr;
			BUS_ACTIVE  <= state != ST_IDLE && state != ST_IGNORE
				&& state != ST_ADDR;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_START_TO_ADDR: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		start_det |=> state == ST_ADDR && bit_cnt == CNT_ZERO)
		else $error("START did not open address phase");

	AST_STOP_TO_IDLE: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		stop_det |=> state == ST_IDLE ##1 !SDA_OE)
		else $error("STOP did not end transfer");

	AST_ADDR_ACK: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		state == ST_ADDR && scl_fall && byte_full(bit_cnt) && addr_match
			&& !start_det && !stop_det |=> ##1 SDA_OE)
		else $error("matching address not acknowledged");

	AST_MISMATCH_QUIET: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		state == ST_IGNORE && $past(state) == ST_IGNORE |=> !SDA_OE)
		else $error("data driven after mismatch");

	AST_PULL_ON_LOW_CLOCK: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		$rose(drive_low) |-> $past(!SCL_IN))
		else $error("data pull started with clock high");

	AST_FIRST_BYTE_MSB: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		state == ST_ADDR_ACK && scl_fall && rx_shift[0] && !stop_det
			&& !start_det && REG_POINTER == PTR_TEMP
			|=> tx_shift == result[11:4])
		else $error("read did not begin with high byte");

endmodule

// >>> verif/tsisf_master.sv
`timescale 1ns/1ps
module tsisf_master
(
	input  wire logic clk,	// Reference clock
	input  wire logic sda,	// Resolved data wire
	output logic      scl,	// Bus clock, master only
	output logic      sda_low	// High while pulling data low
);
	// ------------------------------------------------------------
	// Bus clock pacing, set per test
	// ------------------------------------------------------------
	int half = 10;	// Half period in reference cycles

	// Idle bus: both lines high, clock stands still
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// ------------------------------------------------------------
	// Bus conditions and bit transfers
	// ------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Start or repeated start, data falls with clock high
	task automatic start();
		if (!scl)
		begin
			sda_low <= 1'b0;
			tick(half);
			scl <= 1'b1;
			tick(half);
		end
		sda_low <= 1'b1;
		tick(half);
		scl <= 1'b0;
		tick(2);
	endtask

	// Data rises with clock high to end the transfer
	task automatic stop();
		sda_low <= 1'b1;
		tick(half);
		scl <= 1'b1;
		tick(half);
		sda_low <= 1'b0;
		tick(half);
	endtask

	// Data set while clock low, sampled at end of high phase
	task automatic bit_io(input logic b, output logic r);
		sda_low <= !b;
		tick(half);
		scl <= 1'b1;
		tick(half);
		r = sda;
		scl <= 1'b0;
		tick(2);	// Hold data past the falling clock
	endtask

	// Eight bits MSB first, then receiver acknowledge
	task automatic write_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask

	// Master as receiver; last byte answered with not-acknowledge
	task automatic read_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask
endmodule

// >>> verif/temp_sensor_i2c_slave_front_tb.sv
`timescale 1ns/1ps
module temp_sensor_i2c_slave_front_tb;
	import tsisf_pkg::*;
	typedef struct packed {
		logic signed [15:0] temp;
		logic [1:0]         res;
		logic [11:0]        want;
	} tsisf_row_t;
	typedef struct packed {
		logic         var27;
		tsisf_strap_t pins;
		logic [6:0]   want;
	} tsisf_strow_t;

	logic         ref_clk, sys_rst, sda_out, sda_oe, m_low, scl, sda_wire;
	logic         variant_27, addr_acquire, res_lo, res_hi, bus_active, a;
	tsisf_strap_t strap;
	tsisf_conv_t  conv;
	logic [11:0]  temp_result;
	logic [6:0]   slave_addr, dev_addr;
	logic [7:0]   reg_pointer, x, y, z;
	int           bad_count, n_compared;

	// Conversion rows: raw sixteenths, resolution, stored code
	tsisf_row_t rows [9] = '{'{16'sh04b0, 2'h3, 12'h4b0}, '{16'shfffc, 2'h3, 12'hffc},
		'{16'sh0800, 2'h3, 12'h7ff}, '{16'sh07ff, 2'h3, 12'h7ff},
		'{16'shf700, 2'h3, 12'h800}, '{16'sh0644, 2'h0, 12'h640},
		'{16'sh0647, 2'h1, 12'h644}, '{16'sh0647, 2'h2, 12'h646},
		'{16'shfe70, 2'h3, 12'he70}};
	// Strap rows: {floating, level} per pin, pin 2 first
	tsisf_strow_t strows [6] = '{'{1'b0, 6'b01_00_01, 7'h4d}, '{1'b1, 6'b10_10_10, 7'h37},
		'{1'b1, 6'b00_00_00, 7'h48}, '{1'b1, 6'b10_00_00, 7'h70},
		'{1'b1, 6'b01_10_10, 7'h36}, '{1'b1, 6'b00_00_10, 7'h2c}};

	// Open-drain data wire with pull-up
	assign sda_wire = ~(m_low | sda_oe);

	tsisf_slave uut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .SCL_IN(scl), .SDA_IN(sda_wire),
		.SDA_OUT(sda_out), .SDA_OE(sda_oe), .STRAP(strap), .VARIANT_27(variant_27),
		.ADDR_ACQUIRE(addr_acquire), .CONV(conv), .RES_SEL_LOW(res_lo), .RES_SEL_HIGH(res_hi),
		.TEMP_RESULT(temp_result), .SLAVE_ADDR(slave_addr), .REG_POINTER(reg_pointer),
		.BUS_ACTIVE(bus_active));
	tsisf_master m (.clk(ref_clk), .sda(sda_wire), .scl(scl), .sda_low(m_low));

	// ------------------------------------------------------------
	// Clock, comparison and closing
	// ------------------------------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] want);
		n_compared++;
		if (seen !== want)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, want, seen);
		end
	endtask

	task automatic wrap_up();
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Read both result bytes of the selected register
	task automatic rd_check(input logic [11:0] want);
		m.start();
		m.write_byte({dev_addr, 1'b1}, a);
		check("raddr ack", 16'(a), 16'h1);
		check("active", 16'(bus_active), 16'h1);
		m.read_byte(1'b0, x);
		m.read_byte(1'b1, y);
		m.stop();
		check("msb byte", 16'(x), 16'(want[11:4]));
		check("lsb byte", 16'(y), 16'({want[3:0], LSB_PAD}));
	endtask

	// Pointer write followed by n discarded data bytes
	task automatic wr_seq(input logic [7:0] p, input int n);
		m.start();
		m.write_byte({dev_addr, 1'b0}, a);
		check("waddr ack", 16'(a), 16'h1);
		m.write_byte(p, a);
		check("ptr ack", 16'(a), 16'h1);
		repeat (n)
		begin
			m.write_byte(8'ha5, a);
			check("data ack", 16'(a), 16'h1);
		end
		m.stop();
	endtask

	// Watchdog sized well above the expected run
	initial
	begin
		repeat (80000) @(posedge ref_clk);
		bad_count++;
		wrap_up();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		sys_rst = 1'b1;
		strap = '0;	// Straps settled before any bus activity
		variant_27 = 1'b0;
		addr_acquire = 1'b0;
		conv = '0;
		{res_hi, res_lo} = 2'h3;
		dev_addr = 7'h48;
		bad_count = 0;
		n_compared = 0;
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		check("rst result", 16'(temp_result), 16'h000);
		check("rst ptr", 16'(reg_pointer), 16'h00);
		check("rst oe", 16'({sda_oe, bus_active, sda_out}), 16'h0);
		check("rst addr", 16'(slave_addr), 16'h48);
		rd_check(12'h000);
		// Conversion table, fast and high-speed bus in turn
		foreach (rows[i])
		begin
			conv <= '{valid: 1'b1, temp: rows[i].temp};
			{res_hi, res_lo} <= rows[i].res;
			@(posedge ref_clk);
			conv.valid <= 1'b0;
			repeat (3) @(posedge ref_clk);
			check("result", 16'(temp_result), 16'(rows[i].want));
			m.half = (i % 2 != 0) ? FAST_HALF_CYC : HS_HALF_CYC;
			rd_check(rows[i].want);
		end
		// Bus writes reach only the pointer
		wr_seq(8'h01, 2);
		check("ptr", 16'(reg_pointer), 16'h01);
		check("kept", 16'(temp_result), 16'he70);
		rd_check(12'h000);
		wr_seq(PTR_TEMP, 0);
		// Foreign address: no acknowledge, line left released
		m.start();
		m.write_byte({dev_addr ^ 7'h01, 1'b1}, a);
		check("foreign ack", 16'(a), 16'h0);
		m.read_byte(1'b1, x);
		check("foreign data", 16'({x, bus_active}), 16'h1fe);
		m.stop();
		// Repeated start after a refused byte restarts at the first byte
		m.start();
		m.write_byte({dev_addr, 1'b1}, a);
		m.read_byte(1'b1, x);
		m.start();
		m.write_byte({dev_addr, 1'b1}, a);
		m.read_byte(1'b0, x);
		m.read_byte(1'b0, y);
		m.read_byte(1'b1, z);
		m.tick(4);
		check("nack ends", 16'(bus_active), 16'h0);
		m.stop();
		check("bytes", 16'({x, y}), 16'he700);
		check("wrap byte", 16'(z), 16'he7);
		// Strap decodes through the acquire request
		foreach (strows[i])
		begin
			variant_27 <= strows[i].var27;
			strap <= strows[i].pins;
			addr_acquire <= 1'b1;
			@(posedge ref_clk);
			addr_acquire <= 1'b0;
			repeat (4) @(posedge ref_clk);
			check("strap addr", 16'(slave_addr), 16'(strows[i].want));
		end
		dev_addr = 7'h2c;
		rd_check(12'he70);
		// Straps taken again at start of communication
		variant_27 <= 1'b0;
		strap <= 6'b01_01_01;
		dev_addr = 7'h4f;
		m.tick(4);
		rd_check(12'he70);
		// Reset in mid-run clears the result, straps resampled
		conv <= '{valid: 1'b1, temp: 16'sh0190};
		@(posedge ref_clk);
		conv.valid <= 1'b0;
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		check("rerst result", 16'(temp_result), 16'h000);
		check("rerst addr", 16'(slave_addr), 16'h4f);
		wrap_up();
	end
endmodule
